/* File: rtl/ssa_pkg.sv */
/*
 * constants for the single-slope converter sequencer: register map, field layout,
 * reset values, state codes and timing figures.
 * assumes a 100 MHz clock and a 32-bit avalon-mm register bus.
 */
package ssa_pkg;
    // ------------------------------------------------------------
    // register byte offsets (32-bit words)
    // ------------------------------------------------------------
    localparam logic [3:0] SSA_OFF_SEQ_CFG = 4'h0;
    localparam logic [3:0] SSA_OFF_DIV_LOW = 4'h4;
    localparam logic [3:0] SSA_OFF_CMP_CFG = 4'h8;
    localparam logic [3:0] SSA_OFF_RUN_CFG = 4'hC;
    localparam logic [5:0] SSA_OFF_CMP_RES = 6'h10;
    localparam logic [5:0] SSA_OFF_FLAGS = 6'h14;
    localparam logic [5:0] SSA_OFF_CAPTURE = 6'h18;
    localparam logic [5:0] SSA_OFF_INPUT_LINE_SELECT = 6'h1C;
    localparam logic [7:0] SSA_CFG_RESET = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SSA_B_CALIB = 0;
    localparam int SSA_B_CONT = 1;
    localparam int SSA_B_MULTI = 2;
    localparam int SSA_F_LINE_LO = 3;
    localparam int SSA_F_LINE_HI = 5;
    localparam int SSA_F_REP_LO = 6;
    localparam int SSA_F_REP_HI = 7;
    localparam int SSA_B_MODE = 0;
    localparam int SSA_B_CALLVL = 1;
    localparam int SSA_B_EDGE = 2;
    localparam int SSA_B_DIR = 3;
    localparam int SSA_B_IRQSEQ = 4;
    localparam int SSA_F_CUR_LO = 5;
    localparam int SSA_F_CUR_HI = 7;
    localparam int SSA_B_RUN = 0;
    localparam int SSA_B_RSRC = 1;
    localparam int SSA_F_DIVH_LO = 4;
    localparam int SSA_F_DIVH_HI = 7;
    localparam int SSA_B_OVF = 0;
    localparam int SSA_B_DONE = 1;
    // ------------------------------------------------------------
    // figures
    // ------------------------------------------------------------
    localparam int SSA_DISCHARGE_MULT = 410;
    localparam logic [2:0] SSA_LINE_LAST_VALID = 3'h5;
    localparam logic [1:0] SSA_REP_MAX = 2'h2;
    localparam logic [15:0] SSA_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] SSA_CNT_ZERO = 16'h0000;
    localparam int SSA_CLOCK_MHZ = 100;

    typedef enum logic [2:0] {
        SSA_IDLE = 3'b000,
        SSA_ARM = 3'b001,
        SSA_COUNT = 3'b010,
        SSA_DISCH = 3'b011,
        SSA_NEXT = 3'b100,
        SSA_HOLD = 3'b101
    } ssa_state_t;
endpackage : ssa_pkg

/* File: rtl/ssa_sequencer.sv */
/*
 * single-slope converter sequencer: registers, prescaler, 16-bit conversion timer,
 * capacitor discharge, channel/repeat/calibration sequencing, interrupt pulse.
 * assumes comparator output and ramp start synchronous to clock_in; analog kept outside.
 */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - mode bit: 0 comparator, 1 converter
// - comparator result readable in bit 0
// - charge level 000 off, 001-111 steps
// - ramp source: 0 capacitor, 1 external
// - 16-bit timer measures ramp time
// - timer clocked through 12-bit prescaler
// - overflow sets flag bit 0, interrupt; code: no interrupt of its own, irq only at channel/sequence end
// - down count sets flag on underflow
// - discharge for (prescaler+1)*410 cycles
// - direction bit: 0 up, 1 down
// - edge bit: 0 rising, 1 falling
// - external ramp start launches timer
// - armed output high when awaiting start
// - calibration conversion after each channel
// - calibration level: ground or bandgap
// - repeat field: one, two, three conversions
// - single/sequence and one-shot/continuous modes
// - line select: channel or last channel
// - run bit starts and stops conversion
// - interrupt per channel or per sequence
module ssa_sequencer
    import ssa_pkg::*;
#(
    parameter int DIV_WIDTH = 12,
    parameter int TMR_WIDTH = 16,
    parameter int LINES = 6
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic comparator_in,
    input wire logic ramp_go_input_in,
    output logic timer_armed_output_out,
    output logic [2:0] mux_line_out,
    output logic mux_calib_out,
    output logic calibration_level_select_out,
    output logic [2:0] charge_source_level_out,
    output logic discharge_out,
    output logic irq_out
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (DIV_WIDTH != 12 || TMR_WIDTH != 16 || LINES != 6) begin : g_chk
        $error("ssa_sequencer: only 12-bit divider, 16-bit timer, 6 lines supported");
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] seq_cfg_ff;
    logic [7:0] div_low_ff;
    logic [7:0] cmp_cfg_ff;
    logic [7:0] run_cfg_ff;
    logic [15:0] capture_ff;
    logic ovf_flag_ff;
    logic done_flag_ff;
    logic rd_ack_ff;
    logic [31:0] rdata_ff;
    logic clr_flags;
    logic set_ovf;
    logic set_done;

    wire logic wr_hit = avs_write_in && avs_byteenable_in[0];
    wire logic [5:0] byte_addr = {avs_address_in, 2'b00};

    // writes complete in the request cycle; reads need one cycle for registered data
    assign avs_waitrequest_out = avs_read_in && !rd_ack_ff;
    assign avs_readdata_out = rdata_ff;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            seq_cfg_ff <= SSA_CFG_RESET;
            div_low_ff <= SSA_CFG_RESET;
            cmp_cfg_ff <= SSA_CFG_RESET;
            run_cfg_ff <= SSA_CFG_RESET;
        end else if (enable_in && wr_hit) begin
            case (byte_addr)
                {2'b00, SSA_OFF_SEQ_CFG}: seq_cfg_ff <= avs_writedata_in[7:0];
                {2'b00, SSA_OFF_DIV_LOW}: div_low_ff <= avs_writedata_in[7:0];
                {2'b00, SSA_OFF_CMP_CFG}: cmp_cfg_ff <= avs_writedata_in[7:0];
                {2'b00, SSA_OFF_RUN_CFG}: run_cfg_ff <= avs_writedata_in[7:0];
                default: begin
                end
            endcase
        end
    end

    // reading the flag register clears it; a set in the same cycle wins
    assign clr_flags = avs_read_in && !rd_ack_ff && byte_addr == SSA_OFF_FLAGS;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rd_ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else if (enable_in) begin
            rd_ack_ff <= avs_read_in && !rd_ack_ff;
            case (byte_addr)
                {2'b00, SSA_OFF_SEQ_CFG}: rdata_ff <= {24'h000000, seq_cfg_ff};
                {2'b00, SSA_OFF_DIV_LOW}: rdata_ff <= {24'h000000, div_low_ff};
                {2'b00, SSA_OFF_CMP_CFG}: rdata_ff <= {24'h000000, cmp_cfg_ff};
                {2'b00, SSA_OFF_RUN_CFG}: rdata_ff <= {24'h000000, run_cfg_ff};
                SSA_OFF_CMP_RES: rdata_ff <= {31'h0000_0000, comparator_in};
                SSA_OFF_FLAGS: rdata_ff <= {30'h0000_0000, done_flag_ff, ovf_flag_ff};
                SSA_OFF_CAPTURE: rdata_ff <= {16'h0000, capture_ff};
                SSA_OFF_INPUT_LINE_SELECT: rdata_ff <= {28'h0000000, mux_calib_out, mux_line_out};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ovf_flag_ff <= 1'b0;
            done_flag_ff <= 1'b0;
        end else if (enable_in) begin
            ovf_flag_ff <= set_ovf || (ovf_flag_ff && !clr_flags);
            done_flag_ff <= set_done || (done_flag_ff && !clr_flags);
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire logic continuous_select_mode = cmp_cfg_ff[SSA_B_MODE];
    wire logic edge_falling = cmp_cfg_ff[SSA_B_EDGE];
    wire logic count_down = cmp_cfg_ff[SSA_B_DIR];
    wire logic irq_per_seq = cmp_cfg_ff[SSA_B_IRQSEQ];
    wire logic calib_after_each = seq_cfg_ff[SSA_B_CALIB];
    wire logic continuous_select = seq_cfg_ff[SSA_B_CONT];
    wire logic multi_channel_select = seq_cfg_ff[SSA_B_MULTI];
    wire logic [2:0] input_line_select = seq_cfg_ff[SSA_F_LINE_HI:SSA_F_LINE_LO];
    wire logic [1:0] repeat_count = seq_cfg_ff[SSA_F_REP_HI:SSA_F_REP_LO];
    wire logic run_request = run_cfg_ff[SSA_B_RUN];
    wire logic ramp_source_select = run_cfg_ff[SSA_B_RSRC];
    wire logic [11:0] timer_divider = {run_cfg_ff[SSA_F_DIVH_HI:SSA_F_DIVH_LO], div_low_ff};
    // unused codes 110/111 clamp to the last real line; repeat code 11 acts as 10
    wire logic [2:0] last_line = (input_line_select > SSA_LINE_LAST_VALID)
        ? SSA_LINE_LAST_VALID : input_line_select;
    wire logic [1:0] rep_last = (repeat_count > SSA_REP_MAX) ? SSA_REP_MAX : repeat_count;

    assign calibration_level_select_out = cmp_cfg_ff[SSA_B_CALLVL];
    // current source only drives the capacitor ramp in converter mode
    assign charge_source_level_out = (continuous_select_mode && !ramp_source_select)
        ? cmp_cfg_ff[SSA_F_CUR_HI:SSA_F_CUR_LO] : 3'h0;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    ssa_state_t state_ff;
    ssa_state_t nxt_state;
    logic [11:0] pre_ff;
    logic [15:0] tmr_ff;
    logic [21:0] dis_ff;
    logic [1:0] rep_ff;
    logic [2:0] line_ff;
    logic calib_ff;
    logic cmp_d_ff;
    logic irq_ff;
    logic run_d_ff;
    logic hit_ff;

    wire logic tick = (pre_ff == timer_divider);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pre_ff <= 12'h000;
        end else if (enable_in) begin
            if (state_ff != SSA_COUNT || tick) begin
                pre_ff <= 12'h000;
            end else begin
                pre_ff <= pre_ff + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // conversion sequencing
    // ------------------------------------------------------------
    wire logic cmp_rise = comparator_in && !cmp_d_ff;
    wire logic cmp_fall = !comparator_in && cmp_d_ff;
    wire logic crossing = edge_falling ? cmp_fall : cmp_rise;
    wire logic hit_any = crossing || hit_ff;
    wire logic tmr_end = count_down ? (tmr_ff == SSA_CNT_ZERO) : (tmr_ff == SSA_CNT_MAX);
    wire logic go_ok = ramp_source_select ? ramp_go_input_in : 1'b1;
    wire logic active = continuous_select_mode && run_request;
    wire logic stop_now = !active;
    wire logic rep_done = (rep_ff == rep_last);
    wire logic input_line_select_done = rep_done && (calib_ff || !calib_after_each);
    wire logic seq_done = input_line_select_done && (!multi_channel_select || line_ff == last_line);
    wire logic continuous_select_end = (state_ff == SSA_COUNT) && tick
        && (hit_any || tmr_end);
    wire logic [21:0] dis_len =
        22'((32'(timer_divider) + 32'd1) * SSA_DISCHARGE_MULT);

    assign timer_armed_output_out = (state_ff == SSA_ARM) && ramp_source_select;
    assign discharge_out = (state_ff == SSA_DISCH);
    assign mux_line_out = line_ff;
    assign mux_calib_out = calib_ff;
    assign irq_out = irq_ff;
    assign set_ovf = continuous_select_end && !hit_any;
    assign set_done = continuous_select_end;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SSA_IDLE: begin
                if (active && !run_d_ff) begin
                    nxt_state = SSA_ARM;
                end
            end
            SSA_ARM: begin
                if (stop_now) begin
                    nxt_state = SSA_IDLE;
                end else if (go_ok) begin
                    nxt_state = SSA_COUNT;
                end
            end
            SSA_COUNT: begin
                if (stop_now) begin
                    nxt_state = SSA_IDLE;
                end else if (continuous_select_end) begin
                    nxt_state = ramp_source_select ? SSA_NEXT : SSA_DISCH;
                end
            end
            SSA_DISCH: begin
                if (dis_ff == 22'h000000) begin
                    nxt_state = SSA_NEXT;
                end
            end
            SSA_NEXT: begin
                if (stop_now) begin
                    nxt_state = SSA_IDLE;
                end else if (seq_done && !continuous_select) begin
                    nxt_state = SSA_HOLD;
                end else begin
                    nxt_state = SSA_ARM;
                end
            end
            SSA_HOLD: begin
                if (!run_request) begin
                    nxt_state = SSA_IDLE;
                end
            end
            default: begin
                nxt_state = SSA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_ff <= SSA_IDLE;
            cmp_d_ff <= 1'b0;
            run_d_ff <= 1'b0;
        end else if (enable_in) begin
            state_ff <= nxt_state;
            cmp_d_ff <= comparator_in;
            // one-shot restart needs run cleared first; idle entry after hold forgets it
            run_d_ff <= (state_ff == SSA_HOLD) ? 1'b1 : (run_d_ff && run_request);
        end
    end

    // ------------------------------------------------------------
    // capture timer and discharge
    // ------------------------------------------------------------
    // a crossing between prescaler ticks waits here for the next tick
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            hit_ff <= 1'b0;
        end else if (enable_in) begin
            if (state_ff != SSA_COUNT || tick) begin
                hit_ff <= 1'b0;
            end else if (crossing) begin
                hit_ff <= 1'b1;
            end
        end
    end

    // timer counts on prescaler ticks, stops and captures on crossing
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            tmr_ff <= SSA_CNT_ZERO;
            capture_ff <= SSA_CNT_ZERO;
        end else if (enable_in) begin
            if (state_ff == SSA_ARM) begin
                tmr_ff <= count_down ? SSA_CNT_MAX : SSA_CNT_ZERO;
            end else if (continuous_select_end) begin
                capture_ff <= tmr_ff;
            end else if (state_ff == SSA_COUNT && tick) begin
                tmr_ff <= count_down ? tmr_ff - 16'h0001 : tmr_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            dis_ff <= 22'h000000;
        end else if (enable_in) begin
            if (continuous_select_end) begin
                dis_ff <= dis_len - 22'h000001;
            end else if (state_ff == SSA_DISCH && dis_ff != 22'h000000) begin
                dis_ff <= dis_ff - 22'h000001;
            end
        end
    end

    // repeat, calibration and channel stepping
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rep_ff <= 2'h0;
            line_ff <= 3'h0;
            calib_ff <= 1'b0;
        end else if (enable_in) begin
            if (state_ff == SSA_IDLE || state_ff == SSA_HOLD) begin
                rep_ff <= 2'h0;
                calib_ff <= 1'b0;
                line_ff <= multi_channel_select ? 3'h0 : last_line;
            end else if (state_ff == SSA_NEXT) begin
                if (!rep_done) begin
                    rep_ff <= rep_ff + 2'h1;
                end else if (calib_after_each && !calib_ff) begin
                    calib_ff <= 1'b1;
                end else begin
                    rep_ff <= 2'h0;
                    calib_ff <= 1'b0;
                    if (seq_done) begin
                        line_ff <= multi_channel_select ? 3'h0 : last_line;
                    end else begin
                        line_ff <= line_ff + 3'h1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // interrupt pulse when the channel or the whole sequence completes
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            irq_ff <= 1'b0;
        end else if (enable_in) begin
            irq_ff <= (state_ff == SSA_NEXT) && (irq_per_seq ? seq_done : input_line_select_done);
        end else begin
            irq_ff <= 1'b0;
        end
    end
endmodule // ssa_sequencer

`default_nettype wire

/* File: testbench/ssa_sequencer_props.sv */
/* checker for the converter sequencer: bus answer, armed handshake, discharge length, levels.
   assumes binding to ssa_sequencer, one 100 MHz clock, synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module ssa_sequencer_chk
    import ssa_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic avs_waitrequest_out,
    input wire logic ramp_go_input_in,
    input wire logic timer_armed_output_out,
    input wire logic [2:0] mux_line_out,
    input wire logic calibration_level_select_out,
    input wire logic [2:0] charge_source_level_out,
    input wire logic discharge_out,
    input wire logic irq_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    // ----------------------------------------
    // snooped configuration
    // ----------------------------------------
    logic [7:0] cmp_ff;
    logic [7:0] run_ff;
    logic [7:0] div_ff;
    int dis_ff;
    int dis_len;
    logic wr_ok;
    assign wr_ok = avs_write_in && avs_byteenable_in[0] && !avs_waitrequest_out;
    assign dis_len = (int'({run_ff[7:4], div_ff}) + 1) * SSA_DISCHARGE_MULT;
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cmp_ff <= 8'h00;
            run_ff <= 8'h00;
            div_ff <= 8'h00;
        end else if (wr_ok) begin
            if (avs_address_in == 4'h1) div_ff <= avs_writedata_in[7:0];
            if (avs_address_in == 4'h2) cmp_ff <= avs_writedata_in[7:0];
            if (avs_address_in == 4'h3) run_ff <= avs_writedata_in[7:0];
        end
    end
    // counts discharge length so it can be judged at the falling edge
    always_ff @(posedge clock_in) begin
        if (reset_in || !discharge_out) dis_ff <= 0;
        else dis_ff <= dis_ff + 1;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    read_wait_a: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("read answer timing wrong");
    write_nowait_a: assert property (avs_write_in |-> !avs_waitrequest_out)
        else $error("write stalled");
    irq_pulse_a: assert property (irq_out |=> !irq_out)
        else $error("interrupt longer than one cycle");
    discharge_len_a: assert property ($fell(discharge_out) |-> dis_ff == dis_len)
        else $error("discharge length wrong");
    armed_start_a: assert property (timer_armed_output_out && ramp_go_input_in |=> !timer_armed_output_out)
        else $error("start not taken while armed");
    armed_source_a: assert property (timer_armed_output_out |-> cmp_ff[0] && run_ff[1])
        else $error("armed outside external ramp conversion");
    line_range_a: assert property (mux_line_out <= SSA_LINE_LAST_VALID)
        else $error("channel beyond last line");
    calib_level_a: assert property (cmp_ff == $past(cmp_ff) |-> calibration_level_select_out == cmp_ff[1])
        else $error("calibration level differs from setting");
    charge_level_a: assert property (cmp_ff == $past(cmp_ff) && run_ff == $past(run_ff)
        |-> charge_source_level_out == ((cmp_ff[0] && !run_ff[1]) ? cmp_ff[7:5] : 3'h0))
        else $error("charge level wrong");
    cover property ($fell(discharge_out));
    cover property (timer_armed_output_out && ramp_go_input_in);
    cover property (irq_out);
endmodule // ssa_sequencer_chk
bind ssa_sequencer ssa_sequencer_chk chk_u (.clock_in(clock_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_waitrequest_out(avs_waitrequest_out), .ramp_go_input_in(ramp_go_input_in),
    .timer_armed_output_out(timer_armed_output_out), .mux_line_out(mux_line_out),
    .calibration_level_select_out(calibration_level_select_out),
    .charge_source_level_out(charge_source_level_out), .discharge_out(discharge_out),
    .irq_out(irq_out));
`default_nettype wire

/* File: testbench/ssa_ramp_model.sv */
/* external ramp generator and comparator model: starts a ramp when the timer is armed
   or kicked, flips the comparator after delay_in cycles. assumes one shared clock. */
`timescale 1ns/10ps
`default_nettype none
module ssa_ramp_model (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic armed_in,
    input wire logic kick_in,
    input wire logic falling_in,
    input wire logic [31:0] delay_in,
    output logic go_out,
    output logic cmp_out
);
    logic busy_ff;
    int cnt_ff;
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            busy_ff <= 1'b0;
            go_out <= 1'b0;
            cmp_out <= 1'b0;
            cnt_ff <= 0;
        end else if (!busy_ff) begin
            cmp_out <= falling_in;
            go_out <= armed_in;
            busy_ff <= armed_in || kick_in;
            cnt_ff <= 0;
        end else begin
            cnt_ff <= cnt_ff + 1;
            // start released at the crossing, so a later arm waits for a fresh ramp
            if (cnt_ff == int'(delay_in)) begin
                cmp_out <= !falling_in;
                go_out <= 1'b0;
            end
            if (cnt_ff == int'(delay_in) + 3) busy_ff <= 1'b0;
        end
    end
endmodule // ssa_ramp_model
`default_nettype wire

/* File: testbench/testbench.sv */
/* self-checking bench for the converter sequencer: registers, conversions, sequencing,
   discharge and overflow. assumes ssa_pkg, the ramp model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ssa_pkg::*;
    logic clock_in = 1'b0, reset_in = 1'b1, rd = 1'b0, wr = 1'b0, kick = 1'b0, fall = 1'b0;
    logic arm_q = 1'b0, go, cmp, armed, calib, irq, dis, wreq;
    logic [3:0] adr = 4'h0, be = 4'hF;
    logic [31:0] wdat = 32'h0, q, rdat;
    logic [15:0] c1, c2;
    logic [7:0] cc;
    logic [2:0] line;
    int dly = 20, error_cnt = 0, compares = 0, cyc = 0, irq_n = 0, dis_n = 0;
    logic [3:0] got_q[$], exp_q[$];
    always #5 clock_in = ~clock_in;
    ssa_ramp_model model_u (.clock_in(clock_in), .reset_in(reset_in), .armed_in(armed),
        .kick_in(kick), .falling_in(fall), .delay_in(dly), .go_out(go), .cmp_out(cmp));
    ssa_sequencer dut_u (.clock_in(clock_in), .reset_in(reset_in), .enable_in(1'b1),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .comparator_in(cmp), .ramp_go_input_in(go), .timer_armed_output_out(armed),
        .mux_line_out(line), .mux_calib_out(calib), .calibration_level_select_out(),
        .charge_source_level_out(), .discharge_out(dis), .irq_out(irq));
    always @(posedge clock_in) begin
        cyc++;
        arm_q <= armed;
        if (armed === 1'b1 && arm_q === 1'b0) got_q.push_back({calib, line});
        if (irq === 1'b1) irq_n++;
        if (dis === 1'b1) dis_n++;
        if (cyc == 90000) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t timeout", $time);
            test_done();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        adr <= a;
        rd <= !w;
        wr <= w;
        wdat <= d;
        do begin
            @(posedge clock_in);
        end while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic run_seq(input logic [7:0] seq, input logic [7:0] cmpc, input logic [7:0] runc);
        int r, last, n, k;
        r = (seq[7:6] == 2'b11) ? 2 : int'(seq[7:6]);
        last = (seq[5:3] > 3'h5) ? 5 : int'(seq[5:3]);
        n = 0;
        k = 0;
        got_q.delete();
        exp_q.delete();
        irq_n = 0;
        for (int l = (seq[2] ? 0 : last); l <= last; l++) begin
            repeat (r + 1) exp_q.push_back({1'b0, 3'(l)});
            if (seq[0]) exp_q.push_back({1'b1, 3'(l)});
            n++;
        end
        if (seq[1]) exp_q.push_back({1'b0, 3'(seq[2] ? 0 : last)});
        bus(1'b1, 4'h0, {24'h0, seq});
        bus(1'b1, 4'h2, {24'h0, cmpc});
        bus(1'b1, 4'h3, {24'h0, runc | 8'h01});
        kick <= !runc[1];
        @(posedge clock_in);
        kick <= 1'b0;
        while (irq_n < (cmpc[4] ? 1 : n) && k < 70000) begin
            @(posedge clock_in);
            k++;
        end
        repeat (5) @(posedge clock_in);
        chk(irq_n, cmpc[4] ? 1 : n);
        bus(1'b1, 4'h3, {24'h0, runc});
        if (runc[1]) begin
            chk(got_q.size(), exp_q.size());
            foreach (got_q[i]) chk(got_q[i], exp_q[i]);
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hD3AE));
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            bus(1'b0, 4'(a), 32'h0);
            chk(q, 32'h0);
        end
        bus(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0);
        c1 = 16'($urandom);
        bus(1'b1, 4'h0, {24'h0, c1[7:0]});
        be <= 4'h0;
        bus(1'b1, 4'h0, {24'h0, ~c1[7:0]});
        be <= 4'hF;
        bus(1'b0, 4'h0, 32'h0);
        chk(q, {24'h0, c1[7:0]});
        bus(1'b1, 4'h0, 32'h0);
        for (int v = 0; v < 2; v++) begin
            fall <= v[0];
            repeat (3) @(posedge clock_in);
            bus(1'b0, 4'h4, 32'h0);
            chk(q[0], v[0]);
        end
        fall <= 1'b0;
        cc = {3'($urandom), 3'b000, 1'($urandom), 1'b1};
        c1 = {10'h0, 3'($urandom % 6), 3'b000};
        run_seq(c1[7:0], cc, 8'h02);
        bus(1'b0, 4'h6, 32'h0);
        c2 = q[15:0];
        dly = 21 + ($urandom % 200);
        run_seq(c1[7:0], cc, 8'h02);
        bus(1'b0, 4'h5, 32'h0);
        chk(q[1:0], 2'b10);
        bus(1'b0, 4'h6, 32'h0);
        chk(32'(q[15:0] - c2), 32'(dly - 20));
        c2 = q[15:0];
        fall <= 1'b1;
        run_seq(c1[7:0], cc | 8'h04, 8'h02);
        bus(1'b0, 4'h6, 32'h0);
        chk(q[15:0], c2);
        fall <= 1'b0;
        run_seq(c1[7:0], cc | 8'h08, 8'h02);
        bus(1'b0, 4'h6, 32'h0);
        chk(q[15:0], 16'hFFFF - c2);
        bus(1'b0, 4'h5, 32'h0);
        chk(q[1:0], 2'b10);
        run_seq({2'd0, 3'd2, 3'b101}, cc, 8'h02);
        for (int r = 0; r < 4; r++) begin
            run_seq({2'(r), 3'($urandom), 1'b0, r[0], 1'b0}, cc | 8'h10, 8'h02);
        end
        run_seq({2'd1, 3'd1, 3'b100}, cc | 8'h10, 8'h02);
        bus(1'b1, 4'h1, 32'h2);
        dis_n = 0;
        run_seq(8'h00, {3'b101, 5'b00001}, 8'h00);
        chk(dis_n, 3 * SSA_DISCHARGE_MULT);
        bus(1'b1, 4'h1, 32'h0);
        dly = 200000;
        run_seq(c1[7:0], cc, 8'h02);
        bus(1'b0, 4'h5, 32'h0);
        chk(q[1:0], 2'b11);
        bus(1'b0, 4'h5, 32'h0);
        chk(q[1:0], 2'b00);
        test_done();
    end
endmodule // testbench
`default_nettype wire
